// file: core/strap_cfg_pkg.sv
// constants for the strap loader, loopback steering and indicator block
// assumes one 20 MHz clock and that the strap pins settle before reset release
package strap_cfg_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_KHZ          = 20000;
  localparam int unsigned BLINK_HALF_MS    = 50;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned SWRST_NS         = 800;
  localparam int unsigned SWRST_CYC        = (SWRST_NS * CLK_KHZ + 999999) / 1000000;
  localparam logic [4:0]  STRAP_SETTLE_CYC = 5'h02;
  localparam logic [4:0]  SWRST_CYC_W      = 5'(SWRST_CYC);

  // ==========================================================
  // mode strap codes
  localparam logic [2:0] MODE_10_HALF   = 3'h0;
  localparam logic [2:0] MODE_10_FULL   = 3'h1;
  localparam logic [2:0] MODE_100_HALF  = 3'h2;
  localparam logic [2:0] MODE_100_FULL  = 3'h3;
  localparam logic [2:0] MODE_AN_100HD  = 3'h4;
  localparam logic [2:0] MODE_REPEATER  = 3'h5;
  localparam logic [2:0] MODE_PWR_DOWN  = 3'h6;
  localparam logic [2:0] MODE_ALL_CAP   = 3'h7;

  // ==========================================================
  // control field {speed, autoneg, bit10, duplex} and advert field
  localparam int unsigned CTRL_SPEED_POS  = 3;
  localparam int unsigned CTRL_AN_POS     = 2;
  localparam int unsigned CTRL_DUPLEX_POS = 0;
  localparam logic [3:0]  CTRL_10_HALF    = 4'h0;
  localparam logic [3:0]  CTRL_10_FULL    = 4'h1;
  localparam logic [3:0]  CTRL_100_HALF   = 4'h8;
  localparam logic [3:0]  CTRL_100_FULL   = 4'h9;
  localparam logic [3:0]  CTRL_AN_100     = 4'hc;
  localparam logic [3:0]  CTRL_ALL_CAP    = 4'hd;
  localparam logic [3:0]  ADV_100_HALF    = 4'h4;
  localparam logic [3:0]  ADV_ALL         = 4'hf;
  localparam logic [3:0]  CTRL_RST        = 4'h0;
  localparam logic [3:0]  ADV_RST         = 4'hf;
  localparam logic [4:0]  ADDR_RST        = 5'h00;
  localparam logic [5:0]  SEED_UPPER      = 6'h3f;

  // ==========================================================
  // sequencer states, gray along strap -> run -> soft reset
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_RUN   = 2'h1,
    ST_SWRST = 2'h3
  } seq_state_t;

endpackage

// file: core/phy_strap_config_loopback_led.sv
// strap loader, loopback steering and status indicators of a 10/100 transceiver
// assumes the mac-side and line-side logic share i_clk; strap pins are asynchronous
module phy_strap_config_loopback_led
  import strap_cfg_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = strap_cfg_pkg::BLINK_HALF_CYC
)(
  // clock and hardware reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // shared strap / rmii receive pins
  input  wire logic [1:0] i_rxd_pin,
  input  wire logic       i_crs_dv_pin,
  input  wire logic       i_rxer_pin,
  output logic      [1:0] o_rxd,
  output logic            o_rxd_oe,
  output logic            o_crs_dv,
  output logic            o_crs_dv_oe,
  output logic            o_rxer,
  output logic            o_rxer_oe,
  output logic            o_col,
  output logic            o_col_oe,
  // mac transmit side
  input  wire logic [1:0] i_txd,
  input  wire logic       i_tx_en,
  // line side, already coded and decoded
  input  wire logic [1:0] i_line_rxd,
  input  wire logic       i_line_rx_dv,
  input  wire logic       i_line_rxer,
  input  wire logic       i_line_collision,
  input  wire logic       i_link_up,
  input  wire logic       i_speed_100,
  output logic      [1:0] o_line_txd,
  output logic            o_line_tx_en,
  output logic            o_tx_power_on,
  // control bits from the register side
  input  wire logic       i_near_loop,
  input  wire logic       i_coll_test,
  input  wire logic       i_far_loop,
  input  wire logic       i_isolate_line,
  input  wire logic       i_addr_bypass,
  input  wire logic       i_sw_reset_req,
  input  wire logic       i_wr_ctrl,
  input  wire logic [3:0] i_wr_ctrl_data,
  input  wire logic       i_wr_adv,
  input  wire logic [3:0] i_wr_adv_data,
  input  wire logic       i_wr_special,
  input  wire logic [2:0] i_wr_mode_data,
  input  wire logic [4:0] i_wr_addr_data,
  // management frame address check
  input  wire logic       i_frame_valid,
  input  wire logic       i_frame_is_write,
  input  wire logic [4:0] i_frame_addr,
  output logic            o_frame_accept,
  // configuration and status
  output logic      [3:0] o_ctrl_bits,
  output logic      [3:0] o_adv_bits,
  output logic      [2:0] o_mode,
  output logic      [4:0] o_phy_addr,
  output logic     [10:0] o_scrambler_seed,
  output logic            o_powered_down,
  output logic            o_repeater,
  output logic            o_sw_reset_busy,
  output logic            o_cfg_loaded,
  // indicators
  output logic            o_link_activity_indicator,
  output logic            o_speed_indicator
);

  // ==========================================================
  // strap synchronisers
  logic [3:0] strap_meta_r;
  logic [3:0] strap_sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      strap_meta_r <= 4'h0;
      strap_sync_r <= 4'h0;
    end
    else
    begin
      strap_meta_r <= {i_rxer_pin, i_crs_dv_pin, i_rxd_pin};
      strap_sync_r <= strap_meta_r;
    end
  end

  // synchronised strap fields
  wire logic [2:0] strap_mode = strap_sync_r[2:0];
  wire logic       strap_addr = strap_sync_r[3];

  // ==========================================================
  // strap decode
  logic [3:0] dec_ctrl;
  logic [3:0] dec_adv;

  // register defaults per mode code; n/a advert keeps its reset value
  always_comb
  begin
    dec_ctrl = CTRL_RST;
    dec_adv  = ADV_RST;
    unique case (strap_mode)
      MODE_10_HALF:  dec_ctrl = CTRL_10_HALF;
      MODE_10_FULL:  dec_ctrl = CTRL_10_FULL;
      MODE_100_HALF: dec_ctrl = CTRL_100_HALF;
      MODE_100_FULL: dec_ctrl = CTRL_100_FULL;
      MODE_AN_100HD, MODE_REPEATER:
      begin
        dec_ctrl = CTRL_AN_100;
        dec_adv  = ADV_100_HALF;
      end
      MODE_PWR_DOWN: dec_ctrl = CTRL_RST;
      MODE_ALL_CAP:
      begin
        dec_ctrl = CTRL_ALL_CAP;
        dec_adv  = ADV_ALL;
      end
    endcase
  end

  // ==========================================================
  // sequencer: settle, load straps once, then soft resets
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;

  wire logic cnt_done   = (cnt_r == 5'h00);
  wire logic load_strap = (state_r == ST_STRAP) && cnt_done;
  wire logic swrst_end  = (state_r == ST_SWRST) && cnt_done;
  wire logic swrst_go   = (state_r == ST_RUN) && i_sw_reset_req;

  // next state; strap settle covers the two synchroniser stages
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? 5'h00 : cnt_r - 5'h01;
    unique case (state_r)
      ST_STRAP:
        if (cnt_done)
          state_nxt = ST_RUN;
      ST_RUN:
        if (swrst_go)
        begin
          state_nxt = ST_SWRST;
          cnt_nxt   = SWRST_CYC_W;
        end
      ST_SWRST:
        if (cnt_done)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_STRAP;
    endcase
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= ST_STRAP;
      cnt_r   <= STRAP_SETTLE_CYC;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ==========================================================
  // configuration registers
  logic [3:0] ctrl_r;
  logic [3:0] adv_r;
  logic [2:0] mode_r;
  logic [4:0] addr_r;
  logic       pwrdn_r;
  logic       rptr_r;
  logic       loaded_r;

  // straps load once after release; a soft reset only rereads the mode field
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_r   <= CTRL_RST;
      adv_r    <= ADV_RST;
      mode_r   <= MODE_ALL_CAP;
      addr_r   <= ADDR_RST;
      pwrdn_r  <= 1'b0;
      rptr_r   <= 1'b0;
      loaded_r <= 1'b0;
    end
    else if (load_strap)
    begin
      ctrl_r   <= dec_ctrl;
      adv_r    <= dec_adv;
      mode_r   <= strap_mode;
      addr_r   <= {4'h0, strap_addr};
      pwrdn_r  <= (strap_mode == MODE_PWR_DOWN);
      rptr_r   <= (strap_mode == MODE_REPEATER);
      loaded_r <= 1'b1;
    end
    else
    begin
      if (i_wr_ctrl)
        ctrl_r <= i_wr_ctrl_data;
      if (i_wr_adv)
        adv_r <= i_wr_adv_data;
      if (i_wr_special)
      begin
        mode_r <= i_wr_mode_data;
        addr_r <= i_wr_addr_data;
      end
      if (swrst_end)
      begin
        pwrdn_r <= (mode_r == MODE_PWR_DOWN);
        rptr_r  <= (mode_r == MODE_REPEATER);
      end
    end
  end

  // ==========================================================
  // management address match, registered one-cycle accept
  logic accept_r;

  wire logic addr_hit   = (i_frame_addr == addr_r);
  wire logic bypass_hit = i_addr_bypass && i_frame_is_write;
  wire logic accept_nxt = i_frame_valid && (addr_hit || bypass_hit);

  // accept pulse
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      accept_r <= 1'b0;
    else
      accept_r <= accept_nxt;
  end

  // ==========================================================
  // data path steering
  wire logic full_duplex = ctrl_r[CTRL_DUPLEX_POS];
  wire logic mac_live    = loaded_r && !pwrdn_r && !i_far_loop;
  wire logic half_crs    = !full_duplex && !rptr_r;
  wire logic near_crs    = i_tx_en;
  wire logic line_crs    = i_line_rx_dv || (half_crs && i_tx_en);
  wire logic near_col    = i_coll_test && i_tx_en;
  wire logic line_col    = i_line_collision && !full_duplex;
  wire logic tx_power    = loaded_r && !pwrdn_r && !i_near_loop;

  // receive-side values; near loop takes the coded transmit path
  wire logic [1:0] rxd_nxt = i_near_loop ? i_txd : i_line_rxd;
  wire logic       crs_nxt = i_near_loop ? near_crs : line_crs;
  wire logic       rxer_nxt = i_near_loop ? 1'b0 : i_line_rxer;
  wire logic       col_nxt = i_near_loop ? near_col : line_col;

  // line transmit values; far loop echoes the partner, mac input ignored
  wire logic [1:0] ltxd_nxt = i_far_loop ? i_line_rxd : i_txd;
  wire logic       lten_nxt = i_far_loop ? i_line_rx_dv : i_tx_en;

  logic [1:0] rxd_r;
  logic       crs_r;
  logic       rxer_r;
  logic       col_r;
  logic [1:0] ltxd_r;
  logic       lten_r;

  // one register stage stands in for the coding sublayers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rxd_r  <= 2'h0;
      crs_r  <= 1'b0;
      rxer_r <= 1'b0;
      col_r  <= 1'b0;
      ltxd_r <= 2'h0;
      lten_r <= 1'b0;
    end
    else
    begin
      rxd_r  <= mac_live ? rxd_nxt : 2'h0;
      crs_r  <= mac_live && crs_nxt;
      rxer_r <= mac_live && rxer_nxt;
      col_r  <= mac_live && col_nxt;
      ltxd_r <= tx_power ? ltxd_nxt : 2'h0;
      lten_r <= tx_power && lten_nxt;
    end
  end

  // ==========================================================
  // indicators
  logic [19:0] blink_cnt_r;
  logic        blink_r;

  wire logic blink_wrap = (blink_cnt_r == 20'(BLINK_CYCLES - 1));

  // free-running blink phase; coarse enough to see, cheap to keep
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      blink_cnt_r <= 20'h0;
      blink_r     <= 1'b1;
    end
    else if (blink_wrap)
    begin
      blink_cnt_r <= 20'h0;
      blink_r     <= !blink_r;
    end
    else
      blink_cnt_r <= blink_cnt_r + 20'h1;
  end

  // carrier for the indicator uses the same value as the mac sees
  wire logic activity = crs_r;
  wire logic led_link = i_link_up && (!activity || blink_r);
  wire logic led_spd  = i_speed_100 && !i_isolate_line;

  logic led_link_r;
  logic led_spd_r;

  // indicator outputs registered
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      led_link_r <= 1'b0;
      led_spd_r  <= 1'b0;
    end
    else
    begin
      led_link_r <= led_link;
      led_spd_r  <= led_spd;
    end
  end

  // ==========================================================
  // outputs
  assign o_rxd                     = rxd_r;
  assign o_crs_dv                  = crs_r;
  assign o_rxer                    = rxer_r;
  assign o_col                     = col_r;
  // pins stay released while straps settle, in far loopback or powered down
  assign o_rxd_oe                  = mac_live;
  assign o_crs_dv_oe               = mac_live;
  assign o_rxer_oe                 = mac_live;
  assign o_col_oe                  = mac_live;
  assign o_line_txd                = ltxd_r;
  assign o_line_tx_en              = lten_r;
  assign o_tx_power_on             = tx_power;
  assign o_frame_accept            = accept_r;
  assign o_ctrl_bits               = ctrl_r;
  assign o_adv_bits                = adv_r;
  assign o_mode                    = mode_r;
  assign o_phy_addr                = addr_r;
  assign o_scrambler_seed          = {SEED_UPPER, addr_r};
  assign o_powered_down            = pwrdn_r;
  assign o_repeater                = rptr_r;
  assign o_sw_reset_busy           = (state_r == ST_SWRST);
  assign o_cfg_loaded              = loaded_r;
  assign o_link_activity_indicator = led_link_r;
  assign o_speed_indicator         = led_spd_r;

endmodule

// file: test/strap_props.sv
// checker for the strap loader, loopback steering and indicators
// assumes it is bound into the top module and sees only its ports
module strap_props
  import strap_cfg_pkg::*;
(
  // clock, reset and inputs
  input wire logic        i_clk, i_arst_n, i_near_loop, i_coll_test, i_far_loop,
  input wire logic        i_isolate_line, i_addr_bypass, i_link_up, i_speed_100,
  input wire logic        i_frame_valid, i_frame_is_write, i_tx_en, i_line_rx_dv, i_line_rxer,
  input wire logic [1:0]  i_txd, i_line_rxd,
  input wire logic [4:0]  i_frame_addr,
  // outputs
  input wire logic        o_rxd_oe, o_crs_dv_oe, o_rxer_oe, o_col_oe, o_col, o_crs_dv,
  input wire logic        o_line_tx_en, o_tx_power_on, o_frame_accept, o_powered_down,
  input wire logic        o_sw_reset_busy, o_link_activity_indicator, o_speed_indicator, o_rxer,
  input wire logic [1:0]  o_rxd, o_line_txd,
  input wire logic [4:0]  o_phy_addr,
  input wire logic [10:0] o_scrambler_seed
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // one clock domain, so one clocking and one disable for all
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ====================
  // loopback paths
  near_col_a: assert property (i_near_loop && !i_coll_test |=> !o_col)
    else $error("collision seen in near loopback");
  near_pwr_a: assert property (i_near_loop ##1 i_near_loop |-> !o_tx_power_on && !o_line_tx_en)
    else $error("transmitter active in near loopback");
  near_data_a: assert property (i_near_loop && o_rxd_oe ##1 o_rxd_oe |->
    o_rxd == $past(i_txd) && o_crs_dv == $past(i_tx_en))
    else $error("near loopback data not returned");
  far_iso_a: assert property (i_far_loop |-> !(o_rxd_oe || o_crs_dv_oe || o_rxer_oe || o_col_oe))
    else $error("mac side driven in far loopback");
  rx_err_a: assert property ($past(i_arst_n) |-> o_rxer == $past(o_rxer_oe && !i_near_loop && i_line_rxer))
    else $error("receive error path wrong");
  far_ret_a: assert property (i_far_loop && !i_near_loop && o_tx_power_on ##1 o_tx_power_on |->
    o_line_txd == $past(i_line_rxd) && o_line_tx_en == $past(i_line_rx_dv))
    else $error("far loopback data not returned");

  // ====================
  // indicators; the first edge after release still sees reset-time inputs
  speed_led_a: assert property ($past(i_arst_n) |->
    o_speed_indicator == $past(i_speed_100 && !i_isolate_line))
    else $error("speed indicator wrong");
  link_off_a: assert property (!i_link_up |=> !o_link_activity_indicator)
    else $error("link indicator on without link");
  link_on_a: assert property ($past(i_arst_n) && $past(i_link_up && !o_crs_dv) |->
    o_link_activity_indicator)
    else $error("link indicator off with idle link");

  // ====================
  // management address, scrambler seed, soft reset and power-down
  frame_acc_a: assert property ($past(i_arst_n) |-> o_frame_accept == $past(i_frame_valid &&
    (i_frame_addr == o_phy_addr || i_addr_bypass && i_frame_is_write)))
    else $error("frame accept wrong");
  seed_val_a: assert property (o_scrambler_seed == {SEED_UPPER, o_phy_addr})
    else $error("scrambler seed not from address");
  swrst_len_a: assert property ($rose(o_sw_reset_busy) |->
    ##16 o_sw_reset_busy ##1 !o_sw_reset_busy)
    else $error("soft reset span wrong");
  pd_gate_a: assert property (o_powered_down |-> !o_rxd_oe && !o_tx_power_on)
    else $error("powered down block still active");
endmodule

bind phy_strap_config_loopback_led strap_props u_props (.*);

// file: test/mac_peer.sv
// mac-side transmit model: frames of random dibits, one idle cycle in eight
// assumes the shared clock; lines change just after the rising edge
module mac_peer (
  // clock and frame request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  // transmit lines toward the block
  output logic      [1:0] o_txd,
  output logic            o_tx_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_r;

  initial
  begin
    ph_r    = 3'h0;
    o_txd   = 2'h0;
    o_tx_en = 1'b0;
  end

  // idle lines show the inverse of the last dibit, never a held copy
  always @(posedge i_clk)
  begin
    ph_r    <= ph_r + 3'h1;
    o_tx_en <= i_go && ph_r != 3'h0;
    o_txd   <= (i_go && ph_r != 3'h0) ? 2'($urandom) : ~o_txd;
  end
endmodule

// file: test/phy_strap_config_loopback_led_tb.sv
// testbench for the strap loader, loopback steering and indicators
// assumes a single 20 MHz clock and a short blink period for simulation
module phy_strap_config_loopback_led_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import strap_cfg_pkg::*;
  typedef struct {int c; logic [7:0] v; logic [7:0] m;} note_t;
  logic i_clk = 0, i_arst_n = 0, i_line_rx_dv = 0, i_line_rxer = 0, i_line_collision = 0;
  logic i_link_up = 0, i_speed_100 = 0, i_near_loop = 0, i_coll_test = 0, i_far_loop = 0;
  logic i_isolate_line = 0, i_addr_bypass = 0, i_sw_reset_req = 0, i_wr_ctrl = 0;
  logic i_wr_adv = 0, i_wr_special = 0, i_frame_valid = 0, i_frame_is_write = 0;
  logic go = 0, pw = 0, adr = 0, a, w, b, lk = 0, i_tx_en;
  logic o_rxd_oe, o_crs_dv, o_crs_dv_oe, o_rxer, o_rxer_oe, o_col, o_col_oe, o_line_tx_en;
  logic o_tx_power_on, o_frame_accept, o_powered_down, o_repeater, o_sw_reset_busy;
  logic o_cfg_loaded, o_link_activity_indicator, o_speed_indicator;
  logic [1:0] i_txd, i_line_rxd = 0, o_rxd, o_line_txd;
  logic [2:0] strap = 0, i_wr_mode_data = 0, o_mode, m;
  logic [3:0] i_wr_ctrl_data = 0, i_wr_adv_data = 0, o_ctrl_bits, o_adv_bits, av;
  logic [4:0] i_wr_addr_data = 0, i_frame_addr = 0, o_phy_addr, ad, fa;
  logic [7:0] e;
  logic [10:0] o_scrambler_seed;
  logic [3:0] ct [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hc, 4'h0, 4'hd};
  int failures = 0, total_checks = 0, cyc = 0, n;
  note_t q[$];
  // pin level: the block's driver wins while enabled, else the strap resistor
  wire [1:0] i_rxd_pin = o_rxd_oe ? o_rxd : strap[1:0];
  wire i_crs_dv_pin = o_crs_dv_oe ? o_crs_dv : strap[2];
  wire i_rxer_pin = o_rxer_oe ? o_rxer : adr;

  phy_strap_config_loopback_led #(.BLINK_CYCLES(4)) DUT (.*);
  mac_peer peer (.i_clk(i_clk), .i_go(go), .o_txd(i_txd), .o_tx_en(i_tx_en));

  initial
    forever #25 i_clk = ~i_clk;

  // ====================
  // compare tasks and verdict
  task automatic chk(logic [23:0] got, logic [23:0] exp, string s);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic cmp(note_t t, logic [7:0] got);
    total_checks++;
    if ((got & t.m) !== (t.v & t.m))
    begin
      failures++;
      $display("mismatch at %0t: path got %h exp %h", $time, got & t.m, t.v & t.m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // straps held from before release until one edge past the load edge
  task automatic hw_reset(logic [2:0] md, logic sa);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    strap <= md;
    adr <= sa;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    strap <= ~md;
    adr <= ~sa;
    @(negedge i_clk);
  endtask

  // ====================
  // scoreboard: retire due notes, then note the data path result one cycle on
  always @(negedge i_clk)
  begin
    while (q.size() > 0 && q[0].c < cyc)
      cmp(q.pop_front(), {o_frame_accept, o_col, o_crs_dv, o_rxd, o_line_tx_en, o_line_txd});
    e = i_near_loop ? {1'b0, i_coll_test & i_tx_en, i_tx_en, i_txd, 3'h0}
      : i_far_loop ? {5'h0, i_line_rx_dv, i_line_rxd}
      : {1'b0, i_line_collision, i_line_rx_dv | i_tx_en, i_line_rxd, i_tx_en, i_txd};
    if (pw)
      q.push_back('{cyc, e, 8'h7f});
    cyc++;
  end

  // watchdog, the whole run needs under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge i_clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    void'($urandom(80659));
    for (int k = 7; k < 15; k++)
    begin
      m = 3'(k);
      a = 1'($urandom);
      hw_reset(m, a);
      chk({o_cfg_loaded, o_mode, o_phy_addr}, {1'b1, m, 4'h0, a}, "strap");
      chk({o_ctrl_bits, o_adv_bits}, {ct[m], (m inside {3'h4, 3'h5}) ? 4'h4 : 4'hf}, "bits");
      chk({o_powered_down, o_repeater}, {m == 3'h6, m == 3'h5}, "flags");
      @(posedge i_clk);
      go <= 1'b1;
      n = 0;
      repeat (16) @(negedge i_clk) n += o_crs_dv;
      chk(24'(n > 0), 24'(m inside {3'h0, 3'h2, 3'h4}), "carrier");
      go <= 1'b0;
    end
    $display("strap load test done");
    // rewrite mode, address and bits while powered down, then soft reset
    ad = 5'($urandom_range(31, 2));
    av = 4'($urandom);
    @(posedge i_clk);
    {i_wr_special, i_wr_ctrl, i_wr_adv} <= 3'h7;
    i_wr_mode_data <= 3'h3;
    i_wr_addr_data <= ad;
    i_wr_adv_data <= av;
    @(posedge i_clk);
    {i_wr_special, i_wr_ctrl, i_wr_adv} <= 3'h0;
    strap <= 3'h6;
    @(negedge i_clk);
    chk({o_powered_down, o_mode, o_phy_addr, o_adv_bits}, {1'b1, 3'h3, ad, av}, "wr");
    @(posedge i_clk);
    i_sw_reset_req <= 1'b1;
    @(posedge i_clk);
    i_sw_reset_req <= 1'b0;
    n = 0;
    repeat (24) @(negedge i_clk) n += o_sw_reset_busy;
    chk(24'(n), 24'd17, "busy span");
    chk({o_powered_down, o_mode, o_ctrl_bits}, {1'b0, 3'h3, 4'h0}, "after soft reset");
    $display("soft reset test done");
    // back-to-back frames, matching or not, with and without bypass
    repeat (12)
    begin
      @(posedge i_clk);
      fa = $urandom_range(1) ? ad : 5'($urandom);
      {w, b} = 2'($urandom);
      {i_frame_valid, i_frame_is_write, i_addr_bypass, i_frame_addr} <= {1'b1, w, b, fa};
      q.push_back('{cyc, {fa == ad || b && w, 7'h0}, 8'h80});
    end
    @(posedge i_clk);
    {i_frame_valid, i_addr_bypass} <= 2'h0;
    $display("frame test done");
    // near loopback, far loopback, then normal path, random line traffic
    pw = 1'b1;
    go <= 1'b1;
    for (int i = 0; i < 120; i++)
    begin
      @(posedge i_clk);
      i_near_loop <= i < 40;
      i_far_loop <= i >= 40 && i < 80;
      {i_coll_test, i_line_rx_dv, i_line_collision, i_line_rxd, i_line_rxer, i_speed_100,
       i_isolate_line, i_link_up} <= 9'($urandom);
    end
    @(posedge i_clk);
    pw = 1'b0;
    {i_link_up, i_line_rx_dv} <= 2'h3;
    repeat (2) @(negedge i_clk);
    $display("loopback test done");
    // steady carrier with link: indicator blinks, half period of four
    n = 0;
    repeat (40)
    begin
      @(negedge i_clk);
      n += o_link_activity_indicator && !lk;
      lk = o_link_activity_indicator;
    end
    chk(24'(n >= 4 && n <= 6), 24'h1, "blink");
    go <= 1'b0;
    $display("indicator test done");
    stop_test();
  end
endmodule
